// *** pdt_pin_source.sv ***
// model of the signal source or load on the timer pin
// assumes a pull-up on the pin; the timer's push-pull drive wins while oe_n is low
`timescale 1ns/1ns
module pdt_pin_source (
	// clock
	ref_clk,
	// timer side of the pin
	pin_out,
	pin_oe_n,
	pin_level
);
	input  wire logic ref_clk;
	input  wire logic pin_out;
	input  wire logic pin_oe_n;
	output wire logic pin_level;
	logic drive_en;
	logic drive_val;
	// resolved wire level: timer drive, else source, else pull-up
	assign pin_level = !pin_oe_n ? pin_out : (drive_en ? drive_val : 1'b1);
	initial begin
		drive_en = 1'b0;
		drive_val = 1'b0;
	end
	// drive a steady level, called just after a clock edge
	task automatic hold(input logic v);
		drive_en <= 1'b1;
		drive_val <= v;
	endtask : hold
	// n rising edges, each phase ph clocks long
	task automatic pulses(input int n, input int ph);
		for (int i = 0; i < n; i++) begin
			drive_val <= 1'b0;
			repeat (ph) @(posedge ref_clk);
			drive_val <= 1'b1;
			repeat (ph) @(posedge ref_clk);
		end
	endtask : pulses
endmodule : pdt_pin_source

// *** pdt_pkg.sv ***
// package of register map, field layout and reset values for the prescaled down timer,
// plus the timer pin synchroniser used by the timer core.
// assumes a single system clock and an active-low reset already released synchronously.

package pdt_pkg;

	// ----------------------------------------------------------------
	// register indices and byte addresses
	// ----------------------------------------------------------------
	localparam int unsigned  PDT_ADDR_W          = 12;
	localparam logic [7:0]   PDT_IDX_PRESCALER   = 8'hd2;  // prescaler_count_register
	localparam logic [7:0]   PDT_IDX_COUNT       = 8'hd3;  // count_register
	localparam logic [7:0]   PDT_IDX_STATUS      = 8'hd4;  // timer_status_control
	localparam logic [11:0]  PDT_ADDR_PRESCALER  = {2'h0, PDT_IDX_PRESCALER, 2'h0};
	localparam logic [11:0]  PDT_ADDR_COUNT      = {2'h0, PDT_IDX_COUNT, 2'h0};
	localparam logic [11:0]  PDT_ADDR_STATUS     = {2'h0, PDT_IDX_STATUS, 2'h0};

	// ----------------------------------------------------------------
	// timer_status_control field positions
	// ----------------------------------------------------------------
	localparam int unsigned  PDT_BIT_FLAG        = 7;  // underflow_flag
	localparam int unsigned  PDT_BIT_IRQ_EN      = 6;  // underflow_irq_enable
	localparam int unsigned  PDT_BIT_DIR         = 5;  // pin_direction_select
	localparam int unsigned  PDT_BIT_DOUT        = 4;  // pin data / mode bit
	localparam int unsigned  PDT_BIT_RUN         = 3;  // prescaler_run
	localparam int unsigned  PDT_TAP_LSB         = 0;  // tap_select, 3 bits

	// ----------------------------------------------------------------
	// reset and reload values, timing
	// ----------------------------------------------------------------
	localparam logic [6:0]   PDT_PSC_RELOAD      = 7'h7f;
	localparam logic [7:0]   PDT_CNT_RELOAD      = 8'hff;
	localparam logic [7:0]   PDT_STATUS_RESET    = 8'h00;
	localparam int unsigned  PDT_INT_DIVIDE      = 12;   // internal clock divide ratio
	localparam logic [3:0]   PDT_DIV_LAST        = 4'(PDT_INT_DIVIDE - 1);

	// ----------------------------------------------------------------
	// bus response codes
	// ----------------------------------------------------------------
	localparam logic [1:0]   PDT_RESP_OKAY       = 2'h0;
	localparam logic [1:0]   PDT_RESP_SLVERR     = 2'h2;

endpackage : pdt_pkg

`timescale 1ns/1ns

// two-flop synchroniser for the timer pin with rising edge detection on the settled copy
module pdt_pin_sync (
	// clock and reset
	input  wire logic  clk,
	input  wire logic  rst_n,
	// raw pin and synchronised views
	input  wire logic  pin_raw,
	output logic       pin_level,
	output logic       pin_rise
);

	typedef struct packed {
		logic  meta;
		logic  sync;
		logic  prev;
	} pdt_sync_state_t;

	pdt_sync_state_t  s_q;
	pdt_sync_state_t  s_d;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	// first stage feeds only the second stage
	always_comb begin
		s_d      = s_q;
		s_d.meta = pin_raw;
		s_d.sync = s_q.meta;
		s_d.prev = s_q.sync;
	end

	// state registers
	// reset to the pulled-up idle level so no false rising edge follows reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '1;
		end else begin
			s_q <= s_d;
		end
	end

	// settled level and its rising edge
	assign pin_level = s_q.sync;
	assign pin_rise  = s_q.sync & ~s_q.prev;

endmodule : pdt_pin_sync

// *** pdt_timer.sv ***
// prescaled down timer: 7-bit prescaler, 8-bit down counter, timer pin modes, register slave.
// assumes ref_clk at 25 MHz, an AXI4-Lite master on the register side, and the
// core's stop indication as a level synchronous to ref_clk.

`timescale 1ns/1ns

// Function
// - prescaler fed by clock/12 or pin clock
// - prescaler reloads 7Fh after reaching zero
// - counter decrements on tap, reloads 0FFh
// - counter readable and writable while running
// - tap select picks one of eight taps
// - run clear freezes counter, holds prescaler 7Fh
// - reset sets counter 0FFh, prescaler 7Fh
// - prescaler writable when run bit set
// - zero sets flag; flag and enable interrupt
// - writing 00h or status bit7 sets flag
// - only software clears the underflow flag
// - counter write beats simultaneous decrement to zero
// - direction and data bits select mode
// - gated mode counts clock/12 while pin high
// - event mode counts pin rising edges
// - output mode latches data on flag rise
// - direction set drives pin push-pull
// - wait no effect; interrupt wakes wait, stop
// - stop freezes all except event counting
// - taps divide by 1 through 128
// - prescaler register bit 7 reads zero
module pdt_timer
	import pdt_pkg::*;
(
	// clock and reset
	input  wire logic                   ref_clk,
	input  wire logic                   rst_n,
	// axi4-lite write address
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [PDT_ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic [2:0]             s_axi_awprot,
	// axi4-lite write data
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	// axi4-lite write response
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	output logic [1:0]                  s_axi_bresp,
	// axi4-lite read address
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	input  wire logic [PDT_ADDR_W-1:0]  s_axi_araddr,
	input  wire logic [2:0]             s_axi_arprot,
	// axi4-lite read data
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	// low power state of the core
	input  wire logic                   stop_mode,
	// timer pin
	input  wire logic                   timer_pin_in,
	output logic                        timer_pin_out,
	output logic                        timer_pin_oe_n,
	// interrupt request and wake-up
	output logic                        timer_irq,
	output logic                        timer_wake
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic                   aw_held;   // write address captured
		logic [PDT_ADDR_W-1:0]  aw_addr;
		logic                   w_held;    // write data captured
		logic [7:0]             w_data;
		logic                   w_lane0;   // low byte lane enabled
		logic                   bvalid;
		logic [1:0]             bresp;
		logic                   rvalid;
		logic [7:0]             rdata;
		logic [1:0]             rresp;
		logic [6:0]             psc;       // prescaler count
		logic [7:0]             cnt;       // counter value
		logic                   flag;      // underflow_flag
		logic                   irq_en;    // underflow_irq_enable
		logic                   dir;       // pin_direction_select
		logic                   dout;      // pin data / mode bit
		logic                   run;       // prescaler_run
		logic [2:0]             tap;       // tap_select
		logic [3:0]             div;       // internal divide-by-12 phase
		logic                   pin_drv;   // latched pin output level
	} pdt_state_t;

	localparam pdt_state_t PDT_STATE_RESET = '{
		aw_held: 1'b0, aw_addr: '0, w_held: 1'b0, w_data: 8'h00, w_lane0: 1'b0,
		bvalid: 1'b0, bresp: PDT_RESP_OKAY, rvalid: 1'b0, rdata: 8'h00,
		rresp: PDT_RESP_OKAY, psc: PDT_PSC_RELOAD, cnt: PDT_CNT_RELOAD,
		flag: PDT_STATUS_RESET[PDT_BIT_FLAG], irq_en: PDT_STATUS_RESET[PDT_BIT_IRQ_EN],
		dir: PDT_STATUS_RESET[PDT_BIT_DIR], dout: PDT_STATUS_RESET[PDT_BIT_DOUT],
		run: PDT_STATUS_RESET[PDT_BIT_RUN], tap: PDT_STATUS_RESET[PDT_TAP_LSB +: 3],
		div: 4'h0, pin_drv: 1'b0
	};

	pdt_state_t  q;
	pdt_state_t  d;

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic  rst_meta_q;
	logic  rst_sync_n_q;

	// reset asserts at once and releases after two edges
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_q   <= 1'b0;
			rst_sync_n_q <= 1'b0;
		end else begin
			rst_meta_q   <= 1'b1;
			rst_sync_n_q <= rst_meta_q;
		end
	end

	// ----------------------------------------------------------------
	// timer pin synchroniser
	// ----------------------------------------------------------------
	logic  pin_level;
	logic  pin_rise;

	// pin is brought into the clock domain before any use
	pdt_pin_sync u_pin_sync (
		.clk       (ref_clk),
		.rst_n     (rst_sync_n_q),
		.pin_raw   (timer_pin_in),
		.pin_level (pin_level),
		.pin_rise  (pin_rise)
	);

	// ----------------------------------------------------------------
	// combinational helpers
	// ----------------------------------------------------------------
	logic        mode_event;
	logic        mode_gated;
	logic        frozen;
	logic        div_tick;
	logic        psc_tick;
	logic        cnt_tick;
	logic [6:0]  tap_mask;
	logic        wr_fire;
	logic        wr_psc;
	logic        wr_cnt;
	logic        wr_status;
	logic        hw_zero;
	logic        flag_set;
	logic [7:0]  rd_value;
	logic        rd_hit;

	// mode decode and clock source selection
	always_comb begin
		mode_event = ~q.dir & ~q.dout;
		mode_gated = ~q.dir & q.dout;
		frozen     = stop_mode & ~mode_event;
		div_tick   = (q.div == PDT_DIV_LAST) & ~frozen;
		if (mode_event) begin
			psc_tick = pin_rise & ~frozen;
		end else if (mode_gated) begin
			psc_tick = div_tick & pin_level;
		end else begin
			psc_tick = div_tick;
		end
		psc_tick   = psc_tick & q.run;
		// tap n fires once every 2^n prescaler steps
		tap_mask   = 7'((8'h01 << q.tap) - 8'h01);
		cnt_tick   = psc_tick & ((q.psc & tap_mask) == 7'h00);
	end

	// write decode: a write completes once address and data are both held
	always_comb begin
		wr_fire   = q.aw_held & q.w_held & ~q.bvalid;
		wr_psc    = wr_fire & q.w_lane0 & (q.aw_addr == PDT_ADDR_PRESCALER);
		wr_cnt    = wr_fire & q.w_lane0 & (q.aw_addr == PDT_ADDR_COUNT);
		wr_status = wr_fire & q.w_lane0 & (q.aw_addr == PDT_ADDR_STATUS);
		// decrement to zero loses to a simultaneous counter write
		hw_zero   = cnt_tick & (q.cnt == 8'h01) & ~wr_cnt;
		flag_set  = hw_zero
		          | (wr_cnt & (q.w_data == 8'h00))
		          | (wr_status & q.w_data[PDT_BIT_FLAG]);
	end

	// read decode
	always_comb begin
		rd_value = 8'h00;
		rd_hit   = 1'b1;
		unique case (s_axi_araddr)
			PDT_ADDR_PRESCALER: begin
				rd_value = {1'b0, q.psc};
			end
			PDT_ADDR_COUNT: begin
				rd_value = q.cnt;
			end
			PDT_ADDR_STATUS: begin
				rd_value = {q.flag, q.irq_en, q.dir, q.dout, q.run, q.tap};
			end
			default: begin
				rd_hit   = 1'b0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		d = q;

		// write address and data channels, taken in either order
		if (s_axi_awvalid && !q.aw_held) begin
			d.aw_held = 1'b1;
			d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !q.w_held) begin
			d.w_held  = 1'b1;
			d.w_data  = s_axi_wdata[7:0];
			d.w_lane0 = s_axi_wstrb[0];
		end
		if (wr_fire) begin
			d.aw_held = 1'b0;
			d.w_held  = 1'b0;
			d.bvalid  = 1'b1;
			d.bresp   = ((q.aw_addr == PDT_ADDR_PRESCALER) || (q.aw_addr == PDT_ADDR_COUNT)
			            || (q.aw_addr == PDT_ADDR_STATUS)) ? PDT_RESP_OKAY : PDT_RESP_SLVERR;
		end else if (q.bvalid && s_axi_bready) begin
			d.bvalid  = 1'b0;
		end

		// read channel: answer one cycle after the address is taken
		if (s_axi_arvalid && !q.rvalid) begin
			d.rvalid = 1'b1;
			d.rdata  = rd_value;
			d.rresp  = rd_hit ? PDT_RESP_OKAY : PDT_RESP_SLVERR;
		end else if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end

		// internal divide-by-12 phase, halted in stop unless counting events
		if (!frozen) begin
			d.div = (q.div == PDT_DIV_LAST) ? 4'h0 : 4'(q.div + 4'h1);
		end

		// status and control fields
		if (wr_status) begin
			d.irq_en = q.w_data[PDT_BIT_IRQ_EN];
			d.dir    = q.w_data[PDT_BIT_DIR];
			d.dout   = q.w_data[PDT_BIT_DOUT];
			d.run    = q.w_data[PDT_BIT_RUN];
			d.tap    = q.w_data[PDT_TAP_LSB +: 3];
		end

		// prescaler: held while stopped, reloads after zero, writable while running
		if (!q.run) begin
			d.psc = PDT_PSC_RELOAD;
		end else if (wr_psc) begin
			d.psc = q.w_data[6:0];
		end else if (psc_tick) begin
			d.psc = (q.psc == 7'h00) ? PDT_PSC_RELOAD : 7'(q.psc - 7'h01);
		end

		// counter: software write wins over the decrement
		if (wr_cnt) begin
			d.cnt = q.w_data;
		end else if (cnt_tick) begin
			d.cnt = (q.cnt == 8'h00) ? PDT_CNT_RELOAD : 8'(q.cnt - 8'h01);
		end

		// underflow flag: set beats a simultaneous software clear
		if (flag_set) begin
			d.flag = 1'b1;
		end else if (wr_status) begin
			d.flag = 1'b0;
		end

		// output latch follows the data bit on each flag rising edge
		if (!q.flag && d.flag) begin
			d.pin_drv = d.dout;
		end
	end

	// state registers
	always_ff @(posedge ref_clk or negedge rst_sync_n_q) begin
		if (!rst_sync_n_q) begin
			q <= PDT_STATE_RESET;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// bus handshakes
	assign s_axi_awready  = ~q.aw_held;
	assign s_axi_wready   = ~q.w_held;
	assign s_axi_bvalid   = q.bvalid;
	assign s_axi_bresp    = q.bresp;
	assign s_axi_arready  = ~q.rvalid;
	assign s_axi_rvalid   = q.rvalid;
	assign s_axi_rdata    = {24'h000000, q.rdata};
	assign s_axi_rresp    = q.rresp;

	// pin is driven push-pull as soon as the direction bit is set
	assign timer_pin_oe_n = ~q.dir;
	assign timer_pin_out  = q.pin_drv;

	// interrupt request, also used to leave wait and stop; wait itself changes nothing
	assign timer_irq      = q.flag & q.irq_en;
	assign timer_wake     = q.flag & q.irq_en;

endmodule : pdt_timer

// *** pdt_timer_asserts.sv ***
// concurrent checks on the bus answers and interrupt outputs of the timer
// assumes binding into pdt_timer, seeing only its ports
`timescale 1ns/1ns
module pdt_timer_asserts
	import pdt_pkg::*;
(
	// clock and reset
	input wire logic                  ref_clk,
	input wire logic                  rst_n,
	// bus handshakes
	input wire logic                  s_axi_awvalid,
	input wire logic                  s_axi_awready,
	input wire logic                  s_axi_wvalid,
	input wire logic                  s_axi_wready,
	input wire logic                  s_axi_bvalid,
	input wire logic                  s_axi_arvalid,
	input wire logic                  s_axi_arready,
	input wire logic [PDT_ADDR_W-1:0] s_axi_araddr,
	input wire logic                  s_axi_rvalid,
	input wire logic                  s_axi_rready,
	input wire logic [31:0]           s_axi_rdata,
	input wire logic [1:0]            s_axi_rresp,
	// interrupt outputs
	input wire logic                  timer_irq,
	input wire logic                  timer_wake
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// accepted write with no answer pending, accepted read
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// read address hits one of the three registers
	logic mapped;
	assign mapped = (s_axi_araddr == PDT_ADDR_PRESCALER) || (s_axi_araddr == PDT_ADDR_COUNT)
		|| (s_axi_araddr == PDT_ADDR_STATUS);
	a_wr_answer_time: assert property (wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write answer not on time");
	a_rd_answer_time: assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer not on time");
	a_rd_unmapped: assert property (rd_taken ##0 !mapped |=> s_axi_rresp == PDT_RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	a_rd_mapped_okay: assert property (rd_taken ##0 mapped |=> s_axi_rresp == PDT_RESP_OKAY)
		else $error("mapped read refused");
	a_psc_msb_zero: assert property (rd_taken ##0 s_axi_araddr == PDT_ADDR_PRESCALER |=> s_axi_rdata[31:7] == 25'h0)
		else $error("prescaler msb not zero");
	a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	a_rd_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer not released");
	a_irq_wake_same: assert property (timer_irq == timer_wake)
		else $error("wake differs from irq");
	a_irq_sw_clear: assert property ($fell(timer_irq) |-> s_axi_bvalid)
		else $error("irq dropped without a write");
endmodule : pdt_timer_asserts

bind pdt_timer pdt_timer_asserts u_asserts (
	.ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .timer_irq(timer_irq), .timer_wake(timer_wake)
);

// *** pdt_timer_tb.sv ***
// self-checking bench of the prescaled down timer
// assumes pdt_timer, its checker and the pin source model compiled before it
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin num_errors++; \
	$display("wrong value %s exp %h got %h", nm, exp, got); end end
module pdt_timer_tb
	import pdt_pkg::*;
;
	logic        ref_clk, rst_n, stop_mode, s_axi_bready, s_axi_rready;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        pin_level, timer_pin_out, timer_pin_oe_n, timer_irq, timer_wake;
	int          num_errors, cmp_count;
	pdt_timer uut (.ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .stop_mode(stop_mode), .timer_pin_in(pin_level),
		.timer_pin_out(timer_pin_out), .timer_pin_oe_n(timer_pin_oe_n), .timer_irq(timer_irq), .timer_wake(timer_wake));
	pdt_pin_source src (.ref_clk(ref_clk), .pin_out(timer_pin_out), .pin_oe_n(timer_pin_oe_n), .pin_level(pin_level));
	// 25 MHz clock
	always #20 ref_clk = ~ref_clk;
	// verdict and end of run
	task automatic conclude();
		if (num_errors == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : conclude
	// one register write, both channels offered together
	task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
	endtask : wr
	// one register read
	task automatic rd(input logic [11:0] a, output logic [7:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata[7:0];
		r = s_axi_rresp;
	endtask : rd
	// write expecting an okay answer
	task automatic w(input logic [11:0] a, input logic [7:0] d);
		logic [1:0] r;
		wr(a, d, r);
		`CHK("bresp", PDT_RESP_OKAY, r)
	endtask : w
	// read and compare
	task automatic rchk(input logic [11:0] a, input logic [7:0] e, input string nm);
		logic [7:0] d;
		logic [1:0] r;
		rd(a, d, r);
		`CHK(nm, e, d)
		`CHK("rresp", PDT_RESP_OKAY, r)
	endtask : rchk
	// reset values, unmapped access, run bit cleared
	task automatic t_reset();
		logic [7:0] d;
		logic [1:0] r;
		rchk(PDT_ADDR_PRESCALER, 8'h7f, "prescaler");
		rchk(PDT_ADDR_COUNT, 8'hff, "counter");
		rchk(PDT_ADDR_STATUS, 8'h00, "status");
		rd(12'h000, d, r);
		`CHK("unmapped rresp", PDT_RESP_SLVERR, r)
		wr(12'hffc, 8'h55, r);
		`CHK("unmapped bresp", PDT_RESP_SLVERR, r)
		w(PDT_ADDR_STATUS, 8'h20);
		w(PDT_ADDR_PRESCALER, 8'h10);
		repeat (200) @(posedge ref_clk);
		rchk(PDT_ADDR_PRESCALER, 8'h7f, "held prescaler");
		rchk(PDT_ADDR_COUNT, 8'hff, "frozen counter");
		`CHK("pin oe_n", 1'b0, timer_pin_oe_n)
	endtask : t_reset
	// stop freezes, prescaler written while running
	task automatic t_stop();
		stop_mode <= 1'b1;
		w(PDT_ADDR_STATUS, 8'h28);
		w(PDT_ADDR_PRESCALER, 8'h05);
		w(PDT_ADDR_COUNT, 8'h40);
		// a write without the low byte lane must leave the counter alone
		s_axi_wstrb <= 4'h0;
		w(PDT_ADDR_COUNT, 8'h11);
		s_axi_wstrb <= 4'hf;
		repeat (100) @(posedge ref_clk);
		rchk(PDT_ADDR_PRESCALER, 8'h05, "stopped prescaler");
		rchk(PDT_ADDR_COUNT, 8'h40, "stopped counter");
		stop_mode <= 1'b0;
	endtask : t_stop
	// underflow flag, irq, output latch, software set and clear
	task automatic t_flag();
		int n;
		w(PDT_ADDR_STATUS, 8'h30);
		w(PDT_ADDR_COUNT, 8'h03);
		w(PDT_ADDR_STATUS, 8'h78);
		n = 0;
		while (timer_irq !== 1'b1 && n < 200) begin
			@(posedge ref_clk);
			n++;
		end
		`CHK("irq delay", 1'b1, (n >= 20 && n <= 48))
		`CHK("pin out", 1'b1, timer_pin_out)
		`CHK("wake", 1'b1, timer_wake)
		repeat (300) @(posedge ref_clk);
		`CHK("flag held", 1'b1, timer_irq)
		w(PDT_ADDR_STATUS, 8'h68);
		`CHK("flag cleared", 1'b0, timer_irq)
		w(PDT_ADDR_STATUS, 8'he8);
		`CHK("flag by status", 1'b1, timer_irq)
		`CHK("pin latched", 1'b0, timer_pin_out)
		w(PDT_ADDR_STATUS, 8'h68);
		w(PDT_ADDR_COUNT, 8'h00);
		`CHK("flag by zero", 1'b1, timer_irq)
		w(PDT_ADDR_STATUS, 8'h20);
	endtask : t_flag
	// counter rate for each tap over 128 prescaler steps
	task automatic t_taps();
		logic [7:0] c0;
		logic [7:0] c1;
		logic [1:0] r;
		for (int t = 0; t < 8; t++) begin
			w(PDT_ADDR_STATUS, 8'h28 | 8'(t));
			rd(PDT_ADDR_COUNT, c0, r);
			repeat (1536) @(posedge ref_clk);
			rd(PDT_ADDR_COUNT, c1, r);
			`CHK("tap rate", 1'b1, (int'(8'(c0 - c1)) >= (128 >> t) - 1) && (int'(8'(c0 - c1)) <= (128 >> t) + 1))
		end
	endtask : t_taps
	// gated mode counts only while the pin is high
	task automatic t_gated();
		logic [7:0] c0;
		logic [7:0] c1;
		logic [1:0] r;
		src.hold(1'b0);
		w(PDT_ADDR_STATUS, 8'h18);
		rd(PDT_ADDR_COUNT, c0, r);
		repeat (240) @(posedge ref_clk);
		rd(PDT_ADDR_COUNT, c1, r);
		`CHK("gate low", c0, c1)
		`CHK("pin oe_n input", 1'b1, timer_pin_oe_n)
		src.hold(1'b1);
		repeat (240) @(posedge ref_clk);
		rd(PDT_ADDR_COUNT, c0, r);
		`CHK("gate high", 1'b1, (8'(c1 - c0) >= 8'h12) && (8'(c1 - c0) <= 8'h15))
	endtask : t_gated
	// event mode counts pin edges, also in stop
	task automatic t_event();
		logic [7:0] c0;
		logic [7:0] c1;
		logic [1:0] r;
		w(PDT_ADDR_STATUS, 8'h08);
		src.hold(1'b0);
		stop_mode <= 1'b1;
		rd(PDT_ADDR_COUNT, c0, r);
		src.pulses(5, 3);
		repeat (10) @(posedge ref_clk);
		rd(PDT_ADDR_COUNT, c1, r);
		`CHK("events", 8'h05, 8'(c0 - c1))
		stop_mode <= 1'b0;
	endtask : t_event
	// watchdog
	initial begin
		repeat (40000) @(posedge ref_clk);
		num_errors++;
		conclude();
	end
	// main sequence
	initial begin
		ref_clk = 1'b0;
		rst_n = 1'b0;
		stop_mode = 1'b0;
		s_axi_bready = 1'b1;
		s_axi_rready = 1'b1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
		s_axi_wstrb = 4'hf;
		num_errors = 0;
		cmp_count = 0;
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		t_reset();
		t_stop();
		t_flag();
		t_taps();
		t_gated();
		t_event();
		conclude();
	end
endmodule : pdt_timer_tb
